// ==== fbid_pkg.sv ====
// Package of constants and types for the function BAR and ID block
package fbid_pkg;

  // ***********************************************************
  // Header offsets and field positions
  // ***********************************************************
  localparam logic [11:0] OFF_IDENT      = 12'h000;
  localparam logic [11:0] OFF_CLASS      = 12'h008;
  localparam logic [11:0] OFF_BAR0       = 12'h010;
  localparam logic [11:0] OFF_BOARD      = 12'h02C;
  localparam int          BAR_COUNT      = 6;
  localparam int          BAR_MIN_LOG2   = 4;   // 16 bytes
  localparam int          BAR_MAX_LOG2   = 31;  // 2 GB
  localparam int          TYPE64_BIT     = 2;
  localparam int          PREF_BIT       = 3;
  localparam logic [15:0] ABSENT_ID      = 16'hFFFF;
  localparam logic [15:0] RST_MAKER      = 16'h1AB0; // Arbitrary value
  localparam logic [15:0] RST_PART       = 16'h0001; // Arbitrary value
  localparam logic [15:0] RST_VPART      = 16'h0002; // Arbitrary value
  localparam logic [7:0]  RST_REV        = 8'h01; // Arbitrary value
  localparam logic [7:0]  RST_CLASS      = 8'h00;
  localparam logic [7:0]  RST_SUBCLASS   = 8'h00;
  localparam logic [15:0] RST_BMAKER     = 16'h5E11; // Arbitrary value
  localparam logic [15:0] RST_BPART      = 16'h0C0D; // Arbitrary value

  // ***********************************************************
  // Carried groups
  // ***********************************************************
  typedef struct packed {
    logic [15:0] maker_identifier;
    logic [15:0] part_identifier;
    logic [15:0] virtual_part_identifier;
    logic [7:0]  silicon_revision;
    logic [7:0]  function_class;
    logic [7:0]  function_subclass;
    logic [15:0] board_maker_identifier;
    logic [15:0] board_part_identifier;
  } fbid_ident_s;

  typedef struct packed {
    logic       present;
    logic       is64;
    logic       prefetch;
    logic [4:0] size_log2;
  } fbid_bar_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        is_vf;
    logic [11:0] addr;
    logic [31:0] wdata;
  } fbid_cfg_req_s;

endpackage : fbid_pkg

// ==== fbid_bar_decode.sv ====
// One BAR: config value readback, host base write and base output for the address match
module fbid_bar_decode (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Effective setup of this BAR
  input  wire fbid_pkg::fbid_bar_s cfg,
  input  wire logic              upper_half,
  input  wire fbid_pkg::fbid_bar_s lower_cfg,
  // Host write of the BAR word
  input  wire logic              wr_en,
  input  wire logic [31:0]       wr_data,
  // Readback and decode
  output logic [31:0]            rd_data,
  output logic [31:0]            base
);

  logic [31:0] next_base;
  logic [31:0] mask;

  // Writable bits lie above the window size
  always_comb begin
    mask = 32'h0000_0000;
    if (upper_half) begin
      mask = (lower_cfg.present && lower_cfg.is64) ? 32'hFFFF_FFFF
                                                   : 32'h0000_0000;
    end else if (cfg.present) begin
      mask = 32'hFFFF_FFFF << cfg.size_log2;
    end
    next_base = wr_en ? (wr_data & mask) : base;
  end

  // Base register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base <= 32'h0000_0000;
    end else begin
      base <= next_base;
    end
  end

  // Readback with memory type and prefetch attributes
  always_comb begin
    rd_data = 32'h0000_0000;
    if (upper_half) begin
      rd_data = base;
    end else if (cfg.present) begin
      rd_data = base;
      rd_data[fbid_pkg::TYPE64_BIT] = cfg.is64;
      rd_data[fbid_pkg::PREF_BIT]   = cfg.prefetch;
    end
  end

endmodule : fbid_bar_decode

// ==== fbid_function_config.sv ====
// Per-function BAR setup and read-only identification header
module fbid_function_config #(
  parameter logic [5:0]  BAR_PRESENT  = 6'h01,
  parameter logic [5:0]  BAR_IS64     = 6'h00,
  parameter logic [5:0]  BAR_PREFETCH = 6'h00,
  parameter logic [29:0] BAR_SIZES    = {6{5'h0C}}
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Run-time reconfiguration of the ID set
  input  wire logic                   reconf_valid,
  input  wire fbid_pkg::fbid_ident_s  reconf_ident,
  // Configuration request from the link
  input  wire fbid_pkg::fbid_cfg_req_s cfg_req,
  // Completion
  output logic                        cpl_valid,
  output logic [31:0]                 cpl_data,
  // Memory decode
  input  wire logic [63:0]            mem_addr,
  input  wire logic                   mem_is_vf,
  output logic [5:0]                  bar_hit,
  // Status of the accepted setup
  output logic                        setup_error
);

  // ***********************************************************
  // Elaboration checks
  // ***********************************************************
  generate
    for (genvar c = 0; c < fbid_pkg::BAR_COUNT; c++) begin : g_chk
      if (BAR_SIZES[c*5 +: 5] < 5'(fbid_pkg::BAR_MIN_LOG2))
        $error("BAR size below 16 bytes");
    end
  endgenerate

  // ***********************************************************
  // Effective BAR setup
  // ***********************************************************
  fbid_pkg::fbid_bar_s eff [fbid_pkg::BAR_COUNT];
  logic [5:0]          upper;
  logic [5:0]          bad;

  function automatic logic pair_ok(input int idx);
    return (idx % 2) == 0;
  endfunction : pair_ok

  // Legal pairing only, odd partner forced absent
  always_comb begin
    for (int i = 0; i < fbid_pkg::BAR_COUNT; i++) begin
      eff[i].present   = BAR_PRESENT[i];
      eff[i].is64      = BAR_IS64[i] && pair_ok(i);
      eff[i].prefetch  = BAR_PREFETCH[i];
      eff[i].size_log2 = BAR_SIZES[i*5 +: 5];
      upper[i]         = 1'b0;
      bad[i]           = BAR_IS64[i] && !pair_ok(i);
    end
    for (int i = 1; i < fbid_pkg::BAR_COUNT; i += 2) begin
      if (eff[i-1].present && eff[i-1].is64) begin
        eff[i].present = 1'b0;
        upper[i]       = 1'b1;
        bad[i]         = bad[i] | BAR_PRESENT[i];
      end
    end
  end

  assign setup_error = |bad;

  // ***********************************************************
  // BAR slots, PF and shared VF copies
  // ***********************************************************
  logic [5:0]  pf_wr;
  logic [5:0]  vf_wr;
  logic [31:0] pf_rd   [fbid_pkg::BAR_COUNT];
  logic [31:0] vf_rd   [fbid_pkg::BAR_COUNT];
  logic [31:0] pf_base [fbid_pkg::BAR_COUNT];
  logic [31:0] vf_base [fbid_pkg::BAR_COUNT];

  function automatic logic [2:0] bar_index(input logic [11:0] a);
    return 3'((a - fbid_pkg::OFF_BAR0) >> 2);
  endfunction : bar_index

  function automatic logic in_bar(input logic [11:0] a);
    return a >= fbid_pkg::OFF_BAR0 && a < fbid_pkg::OFF_BAR0 + 12'h018;
  endfunction : in_bar

  generate
    for (genvar b = 0; b < fbid_pkg::BAR_COUNT; b++) begin : g_bar
      assign pf_wr[b] = cfg_req.valid && cfg_req.write && !cfg_req.is_vf &&
                        in_bar(cfg_req.addr) && bar_index(cfg_req.addr) == b;
      assign vf_wr[b] = cfg_req.valid && cfg_req.write && cfg_req.is_vf &&
                        in_bar(cfg_req.addr) && bar_index(cfg_req.addr) == b;
      fbid_bar_decode u_pf (
        .clk        (clk),
        .resetn     (resetn),
        .cfg        (eff[b]),
        .upper_half (upper[b]),
        .lower_cfg  (eff[b - (b % 2)]),
        .wr_en      (pf_wr[b]),
        .wr_data    (cfg_req.wdata),
        .rd_data    (pf_rd[b]),
        .base       (pf_base[b])
      );
      // One setup serves every virtual function
      fbid_bar_decode u_vf (
        .clk        (clk),
        .resetn     (resetn),
        .cfg        (eff[b]),
        .upper_half (upper[b]),
        .lower_cfg  (eff[b - (b % 2)]),
        .wr_en      (vf_wr[b]),
        .wr_data    (cfg_req.wdata),
        .rd_data    (vf_rd[b]),
        .base       (vf_base[b])
      );
    end
  endgenerate

  // ***********************************************************
  // Address decode
  // ***********************************************************
  always_comb begin
    for (int i = 0; i < fbid_pkg::BAR_COUNT; i++) begin
      logic [63:0] mask;
      logic [63:0] base;
      mask = 64'hFFFF_FFFF_FFFF_FFFF << eff[i].size_log2;
      base = {32'h0000_0000, (mem_is_vf ? vf_base[i] : pf_base[i])};
      if (eff[i].is64 && i < fbid_pkg::BAR_COUNT - 1) begin
        base[63:32] = mem_is_vf ? vf_base[i+1] : pf_base[i+1];
      end else begin
        mask[63:32] = 32'hFFFF_FFFF;
      end
      base[3:0] = 4'h0;
      bar_hit[i] = eff[i].present &&
                   ((mem_addr & mask) == (base & mask));
    end
  end

  // ***********************************************************
  // Identification set of this function
  // ***********************************************************
  fbid_pkg::fbid_ident_s ident;
  fbid_pkg::fbid_ident_s next_ident;

  // Only reconfiguration replaces the set, never a host write
  always_comb begin
    next_ident = ident;
    if (reconf_valid) begin
      next_ident = reconf_ident;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ident <= '{fbid_pkg::RST_MAKER, fbid_pkg::RST_PART,
                 fbid_pkg::RST_VPART, fbid_pkg::RST_REV,
                 fbid_pkg::RST_CLASS, fbid_pkg::RST_SUBCLASS,
                 fbid_pkg::RST_BMAKER, fbid_pkg::RST_BPART};
    end else begin
      ident <= next_ident;
    end
  end

  // ***********************************************************
  // Completion path
  // ***********************************************************
  logic        next_cpl_valid;
  logic [31:0] next_cpl_data;
  logic [15:0] part;

  // Reads return header words; writes complete with no data
  always_comb begin
    part           = cfg_req.is_vf ? ident.virtual_part_identifier
                                   : ident.part_identifier;
    next_cpl_valid = cfg_req.valid;
    next_cpl_data  = 32'h0000_0000;
    if (cfg_req.valid && !cfg_req.write) begin
      case (cfg_req.addr)
        fbid_pkg::OFF_IDENT:
          next_cpl_data = {part, ident.maker_identifier};
        fbid_pkg::OFF_CLASS:
          next_cpl_data = {ident.function_class, ident.function_subclass,
                           8'h00, ident.silicon_revision};
        fbid_pkg::OFF_BOARD:
          next_cpl_data = {ident.board_part_identifier,
                           ident.board_maker_identifier};
        default: begin
          if (in_bar(cfg_req.addr)) begin
            next_cpl_data = cfg_req.is_vf ? vf_rd[bar_index(cfg_req.addr)]
                                          : pf_rd[bar_index(cfg_req.addr)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpl_valid <= 1'b0;
      cpl_data  <= 32'h0000_0000;
    end else begin
      cpl_valid <= next_cpl_valid;
      cpl_data  <= next_cpl_data;
    end
  end

endmodule : fbid_function_config

// ==== fbid_function_config_props.sv ====
// Checker of the function BAR and ID block ports
module fbid_function_config_props #(
  parameter logic [5:0] BAR_PRESENT = 6'h01
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    resetn,
  // Requests and reconfiguration
  input wire logic                    reconf_valid,
  input wire fbid_pkg::fbid_ident_s   reconf_ident,
  input wire fbid_pkg::fbid_cfg_req_s cfg_req,
  // Answers and decode
  input wire logic                    cpl_valid,
  input wire logic [31:0]             cpl_data,
  input wire logic [63:0]             mem_addr,
  input wire logic                    mem_is_vf,
  input wire logic [5:0]              bar_hit,
  input wire logic                    setup_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ***********************************************************
  // Completion timing and content
  // ***********************************************************
  property p_cpl_follow;
    cfg_req.valid |=> cpl_valid;
  endproperty
  a_cpl_follow: assert property (p_cpl_follow)
    else $error("completion missing after request");
  property p_cpl_only;
    !cfg_req.valid |=> !cpl_valid;
  endproperty
  a_cpl_only: assert property (p_cpl_only)
    else $error("completion without request");
  property p_wr_zero;
    cfg_req.valid && cfg_req.write |=> cpl_data == 32'h00000000;
  endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("write completion carries data");
  property p_unmapped;
    cfg_req.valid && !cfg_req.write && cfg_req.addr == 12'h040
      |=> cpl_data == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_reconf;
    reconf_valid ##1 (cfg_req.valid && !cfg_req.write && !cfg_req.is_vf
      && cfg_req.addr == 12'h000)
      |=> cpl_data[15:0] == $past(reconf_ident.maker_identifier, 2);
  endproperty
  a_reconf: assert property (p_reconf)
    else $error("reconfigured maker value not returned");

  // ***********************************************************
  // Decode and setup
  // ***********************************************************
  property p_absent;
    (bar_hit & ~BAR_PRESENT) == 6'h00;
  endproperty
  a_absent: assert property (p_absent)
    else $error("absent BAR decoded an address");
  property p_setup;
    !setup_error;
  endproperty
  a_setup: assert property (p_setup)
    else $error("legal pairing flagged as error");
  property p_hit_steady;
    $stable(mem_addr[63:4]) && $stable(mem_is_vf) && !$past(cfg_req.valid)
      |-> $stable(bar_hit);
  endproperty
  a_hit_steady: assert property (p_hit_steady)
    else $error("decode depends on bits below 16 bytes");
endmodule : fbid_function_config_props

// ==== fbid_host_model.sv ====
// Host model issuing configuration requests
module fbid_host_model (
  // Clock
  input  wire logic                    clk,
  // Request and completion
  output fbid_pkg::fbid_cfg_req_s      cfg_req,
  input  wire logic                    cpl_valid,
  input  wire logic [31:0]             cpl_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cfg_req = '0;

  // One access from an edge; reads may repeat freely, no side effect
  task automatic access(input logic wr, input logic vf, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    cfg_req <= '{1'b1, wr, vf, a, d};
    @(posedge clk);
    cfg_req <= '{1'b0, ~wr, ~vf, ~a, ~d}; // Released lines show junk
    @(negedge clk);
    n = 0;
    while (!cpl_valid && n < 3) begin
      @(negedge clk);
      n++;
    end
    ok = cpl_valid;
    q = cpl_data;
    @(posedge clk);
  endtask : access
endmodule : fbid_host_model

// ==== tb_function_bar_and_id_config.sv ====
// Testbench of the function BAR and ID block
module tb_function_bar_and_id_config;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        wr;
    logic        vf;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } fbid_row_s;
  localparam logic [31:0] ID0 = {fbid_pkg::RST_PART, fbid_pkg::RST_MAKER};
  logic                    clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    reconf_valid = 1'b0;
  fbid_pkg::fbid_ident_s   reconf_ident = '0;
  fbid_pkg::fbid_cfg_req_s cfg_req;
  logic                    cpl_valid;
  logic [31:0]             cpl_data;
  logic [63:0]             mem_addr = '0;
  logic                    mem_is_vf = 1'b0;
  logic [5:0]              bar_hit;
  logic                    setup_error;
  int                      bad_count = 0;
  int                      n_tests = 0;
  fbid_row_s rows[17] = '{
    '{1'b0, 1'b0, 12'h000, 32'h0, ID0},
    '{1'b0, 1'b1, 12'h000, 32'h0, {fbid_pkg::RST_VPART, fbid_pkg::RST_MAKER}},
    '{1'b0, 1'b0, 12'h02C, 32'h0, {fbid_pkg::RST_BPART, fbid_pkg::RST_BMAKER}},
    '{1'b0, 1'b0, 12'h008, 32'h0, {fbid_pkg::RST_CLASS, fbid_pkg::RST_SUBCLASS,
      8'h00, fbid_pkg::RST_REV}},
    '{1'b1, 1'b0, 12'h000, 32'hFFFFFFFF, 32'h0},
    '{1'b0, 1'b0, 12'h000, 32'h0, ID0},
    '{1'b1, 1'b0, 12'h010, 32'hFFFFFFFF, 32'h0},
    '{1'b0, 1'b0, 12'h010, 32'h0, 32'hFFFFFFFC},
    '{1'b1, 1'b0, 12'h010, 32'h00001000, 32'h0},
    '{1'b1, 1'b0, 12'h014, 32'h00000001, 32'h0},
    '{1'b0, 1'b0, 12'h014, 32'h0, 32'h00000001},
    '{1'b1, 1'b0, 12'h018, 32'hFFFFFFFF, 32'h0},
    '{1'b0, 1'b0, 12'h018, 32'h0, 32'h80000000},
    '{1'b1, 1'b0, 12'h01C, 32'hFFFFFFFF, 32'h0},
    '{1'b0, 1'b0, 12'h01C, 32'h0, 32'h0},
    '{1'b1, 1'b0, 12'h020, 32'h00003000, 32'h0},
    '{1'b0, 1'b0, 12'h040, 32'h0, 32'h0}};

  // ***********************************************************
  // Clock, design and host
  // ***********************************************************
  always #5 clk = ~clk;
  fbid_function_config #(.BAR_PRESENT(6'h15), .BAR_IS64(6'h01),
    .BAR_PREFETCH(6'h01), .BAR_SIZES({5'h0C, 5'h0C, 5'h0C, 5'h1F, 5'h0C, 5'h04})
  ) u_dut (.clk(clk), .resetn(resetn), .reconf_valid(reconf_valid),
    .reconf_ident(reconf_ident), .cfg_req(cfg_req), .cpl_valid(cpl_valid),
    .cpl_data(cpl_data), .mem_addr(mem_addr), .mem_is_vf(mem_is_vf),
    .bar_hit(bar_hit), .setup_error(setup_error));
  fbid_host_model u_host (.clk(clk), .cfg_req(cfg_req),
    .cpl_valid(cpl_valid), .cpl_data(cpl_data));

  // ***********************************************************
  // Shared tasks
  // ***********************************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic run(input fbid_row_s r);
    logic [31:0] q;
    logic        ok;
    u_host.access(r.wr, r.vf, r.a, r.d, q, ok);
    check(ok, 1'b1);
    if (!ok) begin
      end_of_test();
    end else begin
      check(q, r.e);
    end
  endtask : run
  task automatic hit(input logic vf, input logic [63:0] a, input logic [5:0] e);
    mem_is_vf <= vf;
    mem_addr <= a;
    @(negedge clk);
    check(bar_hit, e);
    @(posedge clk);
  endtask : hit

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) run(rows[i]);
    run('{1'b1, 1'b1, 12'h010, 32'h00002000, 32'h0});
    run('{1'b0, 1'b1, 12'h010, 32'h0, 32'h0000200C});
    run('{1'b1, 1'b1, 12'h018, 32'hFFFFFFFF, 32'h0});
    $display("register rows done");
    hit(1'b0, 64'h000000010000100F, 6'h01);
    hit(1'b0, 64'h0000000100001010, 6'h00);
    hit(1'b0, 64'h00000000FFFFFFFF, 6'h04);
    hit(1'b0, 64'h0000000000003FFF, 6'h10);
    hit(1'b1, 64'h0000000000002004, 6'h01);
    check(setup_error, 1'b0);
    $display("decode done");
    reconf_ident <= '{16'h1234, 16'h5678, 16'h9ABC, 8'h5A, 8'h3C, 8'h7E,
      16'h2468, 16'h1357};
    reconf_valid <= 1'b1;
    @(posedge clk);
    reconf_valid <= 1'b0;
    run('{1'b0, 1'b0, 12'h000, 32'h0, 32'h56781234});
    run('{1'b1, 1'b0, 12'h02C, 32'h0, 32'h0});
    run('{1'b0, 1'b0, 12'h02C, 32'h0, 32'h13572468});
    run('{1'b0, 1'b1, 12'h000, 32'h0, 32'h9ABC1234});
    run('{1'b0, 1'b0, 12'h008, 32'h0, 32'h3C7E005A});
    $display("reconfiguration done");
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    check(cpl_valid, 1'b0);
    resetn <= 1'b1;
    @(posedge clk);
    run('{1'b0, 1'b0, 12'h010, 32'h0, 32'h0000000C});
    run('{1'b0, 1'b0, 12'h000, 32'h0, ID0});
    $display("mid-run reset done");
    end_of_test();
  end
endmodule : tb_function_bar_and_id_config

bind fbid_function_config fbid_function_config_props #(
  .BAR_PRESENT(BAR_PRESENT)
) u_props (.clk(clk), .resetn(resetn), .reconf_valid(reconf_valid),
  .reconf_ident(reconf_ident), .cfg_req(cfg_req), .cpl_valid(cpl_valid),
  .cpl_data(cpl_data), .mem_addr(mem_addr), .mem_is_vf(mem_is_vf),
  .bar_hit(bar_hit), .setup_error(setup_error));
